// file: hdl/kpio_pkg.sv
// Constants shared by the keypad test-function block
`default_nettype none
package kpio_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_SPECIAL = 8'h00;
    localparam logic [7:0] ADDR_FORCE = 8'h04;
    localparam logic [7:0] ADDR_IN_VIEW = 8'h08;
    localparam logic [7:0] ADDR_OUT_VIEW = 8'h0c;
    localparam logic [7:0] ADDR_INCH_SPEED = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_CFG0 = 8'h20;
    localparam logic [7:0] ADDR_FAULT0 = 8'h40;
    // Counts and widths
    localparam int NUM_DO = 6;
    localparam int NUM_DI = 9;
    localparam int NUM_SLOT = 5;
    localparam int NUM_KEY = 5;
    // Special function codes
    localparam logic [15:0] SF_FORCE_ON = 16'h0196;
    localparam logic [15:0] SF_FORCE_OFF = 16'h0190;
    // Reset values and the inch speed limit
    localparam logic [15:0] INCH_SPEED_RST = 16'h0014;
    localparam logic [15:0] INCH_SPEED_MAX = 16'h1388;
    localparam logic [5:0] FORCE_RST = 6'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    // Parameter index on the keypad
    localparam logic [3:0] IDX_SLOT_LAST = 4'h4;
    localparam logic [3:0] IDX_INCH = 4'h5;
    localparam logic [3:0] IDX_IN_VIEW = 4'h6;
    localparam logic [3:0] IDX_OUT_VIEW = 4'h7;
    localparam logic [3:0] IDX_FORCE = 4'h8;
    // Config field layout
    localparam int CFG_INV_BIT = 4;
    // Blink timing
    localparam int CLK_HZ = 125_000_000;
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Keypad screens
    typedef enum logic [1:0] {
        ST_BROWSE = 2'b00,
        ST_SHOW = 2'b01,
        ST_EDIT = 2'b10,
        ST_INCH = 2'b11
    } kpio_state_e;
endpackage : kpio_pkg
`default_nettype wire

// file: hdl/kpio_sync.sv
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module kpio_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Levels
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] sync
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            sync <= '0;
        end else begin
            meta <= pin;
            sync <= meta;
        end
    end
endmodule : kpio_sync
`default_nettype wire

// file: hdl/kpio_fault_mem.sv
// Fault history store, newest first, two registered read ports
`timescale 1ns/1ps
`default_nettype none
module kpio_fault_mem #(
    parameter int DEPTH = 5,
    parameter int DW = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Logging port
    input wire logic wr_en,
    input wire logic [DW-1:0] wr_data,
    // Read ports, slot 0 is newest
    input wire logic [2:0] slot_a,
    output logic [DW-1:0] rd_a,
    input wire logic [2:0] slot_b,
    output logic [DW-1:0] rd_b
);
    logic [DW-1:0] mem [DEPTH];
    logic [2:0] wptr;

    // Map a slot number to a physical entry
    function automatic logic [2:0] phys(input logic [2:0] s);
        logic [3:0] p;
        p = 4'(wptr) + 4'(DEPTH) - 4'd1 - 4'(s);
        if (p >= 4'(DEPTH)) p = p - 4'(DEPTH);
        return p[2:0];
    endfunction : phys

    // Circular write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wptr <= 3'h0;
            for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
        end else if (wr_en) begin
            mem[wptr] <= wr_data;
            wptr <= (wptr == 3'(DEPTH - 1)) ? 3'h0 : wptr + 3'h1;
        end
    end

    // Registered reads
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_a <= '0;
            rd_b <= '0;
        end else begin
            rd_a <= mem[phys(slot_a)];
            rd_b <= mem[phys(slot_b)];
        end
    end
endmodule : kpio_fault_mem
`default_nettype wire

// file: hdl/kpio_top.sv
// Keypad test functions: fault view, inch move, output force, I/O views
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module kpio_top #(
    parameter int BLINK_CYCLES = kpio_pkg::BLINK_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Keypad pins: mode, up, down, shift, set
    input wire logic [kpio_pkg::NUM_KEY-1:0] key_pin,
    // Drive pins and status
    input wire logic servo_enable_pin,
    input wire logic [kpio_pkg::NUM_DI-1:0] discrete_input,
    input wire logic [15:0] drive_status,
    input wire logic fault_log,
    input wire logic [15:0] fault_log_code,
    // Display
    output logic [19:0] disp_value,
    output logic disp_hex,
    output logic [4:0] disp_blank,
    output logic disp_inch,
    // Motor and outputs
    output logic jog_ccw,
    output logic jog_cw,
    output logic [15:0] jog_speed,
    output logic [kpio_pkg::NUM_DO-1:0] discrete_output
);
    import kpio_pkg::*;

    // Assertions below share this clock and reset
    default clocking sva_clk @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ****************************************
    // Input synchronisation and key edges
    // ****************************************
    logic [NUM_KEY+NUM_DI:0] pins_s;
    logic [NUM_KEY-1:0] key_s, key_q, key_hit;
    logic servo_on;
    logic [NUM_DI-1:0] di_s;
    logic k_mode, k_up, k_down, k_shift, k_set;

    kpio_sync #(.WIDTH(NUM_KEY + NUM_DI + 1)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin({key_pin, servo_enable_pin, discrete_input}),
        .sync(pins_s)
    );
    assign key_s = pins_s[NUM_KEY+NUM_DI:NUM_DI+1];
    assign servo_on = pins_s[NUM_DI];
    assign di_s = pins_s[NUM_DI-1:0];

    // Previous key level for press detection
    always_ff @(posedge aclk) begin
        if (!aresetn) key_q <= '0;
        else key_q <= key_s;
    end
    assign key_hit = key_s & ~key_q;
    assign {k_mode, k_up, k_down, k_shift, k_set} = key_hit;

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic [7:0] aw_addr, ar_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_ok, w_ok, wr_en, rd_pend;
    logic [31:0] wr_word, mask;
    logic [15:0] special, inch_speed, edit_speed, fault_a, fault_b;
    logic [5:0] force_value;
    logic [7:0] cfg [NUM_DO];
    logic force_mode, force_eff;
    logic [NUM_DI-1:0] in_view;
    logic [NUM_DO-1:0] out_view, normal_do;
    kpio_state_e state;

    assign wr_en = aw_ok && w_ok && !s_axi_bvalid;

    // Address decode, 1 when mapped
    function automatic logic mapped(input logic [7:0] a);
        return a[1:0] == 2'h0 && (a <= ADDR_STATUS ||
            (a >= ADDR_CFG0 && a < ADDR_CFG0 + 8'(4 * NUM_DO)) ||
            (a >= ADDR_FAULT0 && a < ADDR_FAULT0 + 8'(4 * NUM_SLOT)));
    endfunction : mapped

    // Register read mux, fault slots come from memory port a
    function automatic logic [31:0] rd_word(input logic [7:0] a);
        logic [7:0] c;
        c = a - ADDR_CFG0;
        if (a >= ADDR_FAULT0) return {16'h0000, fault_a};
        if (a >= ADDR_CFG0) return {24'h000000, cfg[c[4:2]]};
        unique case (a)
            ADDR_SPECIAL: return {16'h0000, special};
            ADDR_FORCE: return {26'h0000000, force_value};
            ADDR_IN_VIEW: return {23'h000000, in_view};
            ADDR_OUT_VIEW: return {26'h0000000, out_view};
            ADDR_INCH_SPEED: return {16'h0000, inch_speed};
            ADDR_STATUS: return {26'h0000000, jog_ccw, jog_cw, servo_on,
                state == ST_INCH, force_eff, force_mode};
            default: return 32'h00000000;
        endcase
    endfunction : rd_word

    // Byte-lane merge of write data over the current contents
    always_comb begin
        mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}},
            {8{w_strb[0]}}};
        wr_word = (rd_word(aw_addr) & ~mask) | (w_data & mask);
    end

    // Write channel: take address and data in any order, answer after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok <= 1'b0;
            w_ok <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_en) begin
                aw_ok <= 1'b0;
                w_ok <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel: memory read in the accept cycle, data one edge later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
            rd_pend <= 1'b0;
            ar_addr <= 8'h00;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                ar_addr <= s_axi_araddr;
                rd_pend <= 1'b1;
                s_axi_arready <= 1'b0;
            end
            if (rd_pend) begin
                rd_pend <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= mapped(ar_addr) ? rd_word(ar_addr) : '0;
                s_axi_rresp <= mapped(ar_addr) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ****************************************
    // Output force and normal output control
    // ****************************************
    // Special function code and force mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            special <= 16'h0000;
            force_mode <= 1'b0;
        end else begin
            if (wr_en && aw_addr == ADDR_SPECIAL) begin
                special <= wr_word[15:0];
                if (wr_word[15:0] == SF_FORCE_ON)
                    force_mode <= 1'b1;
                else if (wr_word[15:0] == SF_FORCE_OFF)
                    force_mode <= 1'b0;
            end
            if (servo_on) force_mode <= 1'b0;
        end
    end
    assign force_eff = force_mode && !servo_on;

    // Force value, cleared at power-up
    always_ff @(posedge aclk) begin
        if (!aresetn) force_value <= FORCE_RST;
        else if (wr_en && aw_addr == ADDR_FORCE) force_value <= wr_word[5:0];
    end

    // Output function configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_DO; i++) cfg[i] <= CFG_RST;
        end else if (wr_en && aw_addr >= ADDR_CFG0 &&
                     aw_addr < ADDR_CFG0 + 8'(4 * NUM_DO)) begin
            cfg[3'((aw_addr - ADDR_CFG0) >> 2)] <= wr_word[7:0];
        end
    end

    // Per-output function: code 0 off, else a drive signal, maybe inverted
    for (genvar g = 0; g < NUM_DO; g++) begin : g_do
        assign normal_do[g] = (cfg[g][3:0] == 4'h0) ? 1'b0 :
            drive_status[cfg[g][3:0]] ^ cfg[g][CFG_INV_BIT];
    end

    // Output drivers and status views
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            discrete_output <= '0;
            in_view <= '0;
            out_view <= '0;
        end else begin
            discrete_output <= force_eff ? force_value : normal_do;
            out_view <= discrete_output;
            in_view <= di_s;
        end
    end

    // ****************************************
    // Fault history
    // ****************************************
    logic [3:0] idx;

    kpio_fault_mem #(.DEPTH(NUM_SLOT), .DW(16)) u_fault (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(fault_log),
        .wr_data(fault_log_code),
        .slot_a(3'((s_axi_araddr - ADDR_FAULT0) >> 2)),
        .rd_a(fault_a),
        .slot_b(idx[2:0]),
        .rd_b(fault_b)
    );

    // ****************************************
    // Keypad screens and inch speed
    // ****************************************
    logic [2:0] cursor;
    logic [31:0] blink_cnt;
    logic blink_on;

    // Edit step for the selected decimal digit
    function automatic logic [15:0] step(input logic [2:0] c);
        unique case (c)
            3'h0: return 16'h0001;
            3'h1: return 16'h000a;
            3'h2: return 16'h0064;
            3'h3: return 16'h03e8;
            default: return 16'h2710;
        endcase
    endfunction : step

    // Screen state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_BROWSE;
            idx <= 4'h0;
        end else begin
            unique case (state)
                ST_BROWSE: begin
                    if (k_up) idx <= (idx == IDX_FORCE) ? 4'h0 : idx + 4'h1;
                    else if (k_down)
                        idx <= (idx == 4'h0) ? IDX_FORCE : idx - 4'h1;
                    else if (k_set)
                        state <= (idx == IDX_INCH) ? ST_EDIT : ST_SHOW;
                end
                ST_SHOW: if (k_mode) state <= ST_BROWSE;
                ST_EDIT: begin
                    if (k_set) state <= ST_INCH;
                    else if (k_mode) state <= ST_BROWSE;
                end
                ST_INCH: if (k_mode) state <= ST_BROWSE;
            endcase
        end
    end

    // Working copy of the speed and the edit cursor
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            edit_speed <= INCH_SPEED_RST;
            cursor <= 3'h0;
        end else if (state == ST_EDIT) begin
            if (k_up) edit_speed <= (edit_speed > INCH_SPEED_MAX -
                step(cursor)) ? INCH_SPEED_MAX : edit_speed + step(cursor);
            else if (k_down) edit_speed <= (edit_speed < step(cursor)) ?
                16'h0000 : edit_speed - step(cursor);
            else if (k_shift)
                cursor <= (cursor == 3'h4) ? 3'h0 : cursor + 3'h1;
        end else begin
            edit_speed <= inch_speed;
            cursor <= 3'h0;
        end
    end

    // Stored inch speed, keypad confirm has priority over the bus
    always_ff @(posedge aclk) begin
        if (!aresetn) inch_speed <= INCH_SPEED_RST;
        else if (state == ST_EDIT && k_set) inch_speed <= edit_speed;
        else if (wr_en && aw_addr == ADDR_INCH_SPEED)
            inch_speed <= (wr_word[15:0] > INCH_SPEED_MAX) ?
                INCH_SPEED_MAX : wr_word[15:0];
    end

    // Blink phase for the edited digit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_cnt <= 32'h00000000;
            blink_on <= 1'b0;
        end else if (blink_cnt == 32'(BLINK_CYCLES - 1)) begin
            blink_cnt <= 32'h00000000;
            blink_on <= !blink_on;
        end else begin
            blink_cnt <= blink_cnt + 32'h00000001;
        end
    end

    // Jog commands, only while in inch mode with the drive on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            jog_ccw <= 1'b0;
            jog_cw <= 1'b0;
            jog_speed <= INCH_SPEED_RST;
        end else begin
            jog_ccw <= state == ST_INCH && servo_on && key_s[3] &&
                !key_s[2];
            jog_cw <= state == ST_INCH && servo_on && key_s[2] &&
                !key_s[3];
            jog_speed <= inch_speed;
        end
    end

    // Display contents
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            disp_value <= 20'h00000;
            disp_hex <= 1'b0;
            disp_blank <= 5'h00;
            disp_inch <= 1'b0;
        end else begin
            disp_inch <= state == ST_INCH;
            disp_hex <= state == ST_SHOW;
            disp_blank <= 5'h00;
            unique case (state)
                ST_BROWSE: disp_value <= {16'h0000, idx};
                ST_SHOW: begin
                    if (idx <= IDX_SLOT_LAST)
                        disp_value <= {4'h0, fault_b};
                    else if (idx == IDX_IN_VIEW)
                        disp_value <= {11'h000, in_view};
                    else if (idx == IDX_OUT_VIEW)
                        disp_value <= {14'h0000, out_view};
                    else disp_value <= {14'h0000, force_value};
                    disp_blank <= 5'h10;
                end
                ST_EDIT: begin
                    disp_value <= {4'h0, edit_speed};
                    disp_blank <= blink_on ? 5'(1 << cursor) : 5'h00;
                end
                ST_INCH: disp_value <= {4'h0, inch_speed};
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence sf_write(logic [15:0] code);
        wr_en && aw_addr == ADDR_SPECIAL && wr_word[15:0] == code;
    endsequence
    sequence confirm_edit;
        state == ST_EDIT && k_set;
    endsequence

    force_on_a: assert property (
        sf_write(SF_FORCE_ON) ##0 !servo_on |=> force_mode)
        else $error("force mode not entered");
    force_off_a: assert property (
        sf_write(SF_FORCE_OFF) |=> !force_mode)
        else $error("force mode not left");
    force_drive_a: assert property (
        force_eff |=> discrete_output == $past(force_value))
        else $error("forced outputs wrong");
    normal_drive_a: assert property (
        servo_on |=> discrete_output == $past(normal_do))
        else $error("force acted while enabled");
    force_release_a: assert property (
        servo_on |=> !force_mode)
        else $error("force kept while enabled");
    jog_gate_a: assert property (
        !servo_on |=> !jog_ccw && !jog_cw)
        else $error("jog while disabled");
    jog_dir_a: assert property (
        state == ST_INCH && servo_on && key_s == 5'h08 |=> jog_ccw && !jog_cw)
        else $error("up key did not run ccw");
    inch_enter_a: assert property (
        confirm_edit |=> state == ST_INCH && inch_speed == $past(edit_speed)
        ##1 disp_inch)
        else $error("inch entry wrong");
    inch_exit_a: assert property (
        state == ST_INCH && k_mode |=> state == ST_BROWSE && idx == IDX_INCH)
        else $error("inch exit wrong");
    speed_reset_a: assert property (
        $rose(aresetn) |-> inch_speed == INCH_SPEED_RST)
        else $error("inch speed reset wrong");
    in_view_a: assert property (
        ##1 in_view == $past(di_s))
        else $error("input view wrong");
    out_view_a: assert property (
        ##1 out_view == $past(discrete_output))
        else $error("output view wrong");
endmodule : kpio_top
`default_nettype wire

// file: sim/kpio_keypad.sv
// Operator keypad model: five key contacts seen as pin levels
`timescale 1ns/1ps
`default_nettype none
module kpio_keypad (
    // Clock
    input wire logic aclk,
    // Keys the operator holds: mode, up, down, shift, set
    input wire logic [4:0] hold,
    // Contact levels at the pins
    output logic [4:0] key_pin
);
    // Contacts follow the operator's fingers one edge later
    always_ff @(posedge aclk) begin
        key_pin <= hold;
    end
endmodule : kpio_keypad
`default_nettype wire

// file: sim/tb.sv
// Self-checking testbench for the keypad test-function block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import kpio_pkg::*;
    logic aclk, aresetn, awv, wv, bre, arv, rre, servo, flog;
    logic awr, wr_, bv, arr, rv, dh, dinch, jccw, jcw;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat, rd;
    logic [1:0] br, rr, lresp;
    logic [4:0] keys, kp, db, acc;
    logic [8:0] di;
    logic [15:0] ds, fcode, js;
    logic [19:0] dv;
    logic [5:0] dout;
    int err_count, n_checks, seed, v;
    kpio_keypad pad (.aclk(aclk), .hold(keys), .key_pin(kp));
    kpio_top #(.BLINK_CYCLES(8)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .key_pin(kp),
        .servo_enable_pin(servo), .discrete_input(di), .drive_status(ds),
        .fault_log(flog), .fault_log_code(fcode), .disp_value(dv),
        .disp_hex(dh), .disp_blank(db), .disp_inch(dinch), .jog_ccw(jccw),
        .jog_cw(jcw), .jog_speed(js), .discrete_output(dout));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Outputs a force value turns on, bit 0 is output 1
    function automatic logic [5:0] force_outs(input int val);
        return 6'(val);
    endfunction : force_outs
    // Bus write, both channels offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_) wv <= 1'b0;
        end while (bv !== 1'b1);
        lresp = br;
    endtask : wr
    // Bus read
    task automatic rdr(input logic [7:0] a);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(posedge aclk);
            if (arv && arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rd = rdat;
        lresp = rr;
    endtask : rdr
    // Press and release one key
    task automatic key(input int b);
        keys[b] <= 1'b1;
        repeat (6) @(posedge aclk);
        keys[b] <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask : key
    // Verdict
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    // Clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        end_of_test();
    end
    // Main sequence
    initial begin
        seed = 32'h4c140b3b;
        {aresetn, awv, wv, bre, arv, rre, servo, flog} = 8'h00;
        {awa, ara, wd, keys, di, ds, fcode} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        rdr(ADDR_INCH_SPEED);
        chk(rd, 32'h14);
        chk(lresp, RESP_OKAY);
        fcode <= 16'h00a5;
        flog <= 1'b1;
        @(posedge aclk);
        flog <= 1'b0;
        key(0);
        chk(dv, 20'h000a5);
        chk({dh, db}, {1'b1, 5'h10});
        key(4);
        repeat (5) key(3);
        key(0);
        chk(dv, 20'h00014);
        key(3);
        chk(dv, 20'h00015);
        key(1);
        acc = 5'h00;
        repeat (16) begin
            @(posedge aclk);
            acc = acc | db;
        end
        chk(acc, 5'h02);
        key(0);
        chk({dinch, js}, {1'b1, 16'h0015});
        servo <= 1'b1;
        keys[3] <= 1'b1;
        repeat (6) @(posedge aclk);
        chk({jccw, jcw}, 2'b10);
        keys[3] <= 1'b0;
        repeat (6) @(posedge aclk);
        chk({jccw, jcw}, 2'b00);
        keys[2] <= 1'b1;
        repeat (6) @(posedge aclk);
        chk({jccw, jcw}, 2'b01);
        servo <= 1'b0;
        repeat (6) @(posedge aclk);
        chk({jccw, jcw}, 2'b00);
        keys[2] <= 1'b0;
        @(posedge aclk);
        key(4);
        chk(dinch, 1'b0);
        key(0);
        chk(dv, 20'h00015);
        key(4);
        $display("keypad test done");
        wr(ADDR_FORCE, 32'h3f);
        repeat (3) @(posedge aclk);
        chk(dout, 6'h00);
        wr(ADDR_SPECIAL, SF_FORCE_ON);
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 7 : $random(seed);
            wr(ADDR_FORCE, v);
            repeat (3) @(posedge aclk);
            chk(dout, force_outs(v));
            rdr(ADDR_OUT_VIEW);
            chk(rd, v[5:0]);
        end
        servo <= 1'b1;
        repeat (5) @(posedge aclk);
        chk(dout, 6'h00);
        servo <= 1'b0;
        repeat (5) @(posedge aclk);
        chk(dout, 6'h00);
        wr(ADDR_SPECIAL, SF_FORCE_ON);
        wr(ADDR_FORCE, 6'h3f);
        wr(ADDR_SPECIAL, SF_FORCE_OFF);
        repeat (3) @(posedge aclk);
        chk(dout, 6'h00);
        wr(ADDR_CFG0, 32'h01);
        ds <= 16'h0002;
        repeat (3) @(posedge aclk);
        chk(dout, 6'h01);
        $display("force test done");
        di <= 9'($random(seed));
        repeat (5) @(posedge aclk);
        rdr(ADDR_IN_VIEW);
        chk(rd, di);
        wr(8'h18, 32'h1);
        chk(lresp, RESP_SLVERR);
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        rdr(ADDR_FORCE);
        chk({rd[5:0], dout}, 12'h000);
        $display("view and reset test done");
        end_of_test();
    end
endmodule : tb
`default_nettype wire
